/* logic/tpw_pkg.sv */
// constants and types shared by the 8-bit pwm timer
package tpw_pkg;

  // counter limits
  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX    = 8'hff;

  // register byte offsets on the bus
  localparam int         REG_AW       = 8;
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_COUNT    = 8'h04;
  localparam logic [7:0] OFS_COMPARE  = 8'h08;
  localparam logic [7:0] OFS_STATUS   = 8'h0c;

  // status bit positions
  localparam int ST_OVF   = 0;
  localparam int ST_MATCH = 1;
  localparam int ST_OCOUT = 2;

  // control word: port level, pin direction, clock select, output mode,
  // waveform mode, msb first
  localparam int CTRL_W = 9;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 9'h000;

  typedef struct packed {
    logic       port_level;
    logic       pin_dir;
    logic [2:0] clk_sel;
    logic [1:0] compare_output_mode;
    logic [1:0] waveform_mode_sel;
  } tpw_ctrl_t;

  // waveform modes in selector order
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_PHASE,
    MODE_CTC,
    MODE_FAST
  } tpw_mode_t;

  // compare output mode codes
  localparam logic [1:0] COM_OFF    = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR  = 2'h2;
  localparam logic [1:0] COM_SET    = 2'h3;

  // clock select codes and prescaler masks
  localparam logic [2:0] CS_STOP    = 3'h0;
  localparam logic [2:0] CS_DIV1    = 3'h1;
  localparam logic [2:0] CS_DIV8    = 3'h2;
  localparam logic [2:0] CS_DIV64   = 3'h3;
  localparam logic [2:0] CS_DIV256  = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam int         PRE_W      = 10;
  localparam logic [9:0] MASK_8     = 10'h007;
  localparam logic [9:0] MASK_64    = 10'h03f;
  localparam logic [9:0] MASK_256   = 10'h0ff;
  localparam logic [9:0] MASK_1024  = 10'h3ff;

  // ahb-lite codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

endpackage

/* logic/tpw_prescaler.sv */
// prescaler turning the i/o clock into a one-cycle timer tick enable
`timescale 1ns/1ns
`default_nettype none
module tpw_prescaler
  import tpw_pkg::*;
(
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  // selection
  input  wire logic [2:0] clk_sel_in,
  // tick enable
  output var  logic       tick_out
);

  logic [PRE_W-1:0] pre_r;
  logic             tick_nxt;

  // free running, shared by all divide ratios
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + 10'h001;
    end
  end

  // codes above the last ratio select an external source that is not
  // wired here, so the timer stands still
  always_comb begin
    unique case (clk_sel_in)
      CS_DIV1:    tick_nxt = 1'b1;
      CS_DIV8:    tick_nxt = (pre_r & MASK_8) == MASK_8;
      CS_DIV64:   tick_nxt = (pre_r & MASK_64) == MASK_64;
      CS_DIV256:  tick_nxt = (pre_r & MASK_256) == MASK_256;
      CS_DIV1024: tick_nxt = (pre_r & MASK_1024) == MASK_1024;
      default:    tick_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= tick_nxt;
    end
  end

endmodule // tpw_prescaler
`default_nettype wire

/* logic/tpw_timer8_pwm.sv */
// 8-bit timer with fast and phase-correct pwm, ahb-lite registers
//
// Notes on behaviour
// - selector 3: single-slope up count, restart bottom
// - fast: at max, clear on next tick
// - fast mode 2: clear on match, set bottom
// - fast mode 3: set on match, clear bottom
// - fast: overflow flag set reaching max
// - pin driven only when direction is output
// - fast period 256 prescaled ticks
// - fast extremes: bottom spike, max constant level
// - fast mode 1 toggles output on match
// - fast compare value is double buffered
// - selector 1: dual-slope up then down
// - phase: clear up-match, set down-match; 3 inverts
// - eight bits; max held one tick, reverse
// - phase: overflow flag set reaching bottom
// - phase period 510 prescaled ticks
// - phase extremes: bottom low, max high
// - leaving max: up-match level at period start
// - missed up match still makes up transition
// - synchronous; tick only as clock enable
// - bottom is 0x00, max is 0xff
// - output mode zero gives pin to port
// - fast modes 2 and 3, compare at max: match ignored
//
// Register access over AHB-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module tpw_timer8_pwm
  import tpw_pkg::*;
(
  // clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        RESET_N_IN,
  // ahb-lite slave
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [2:0]  HSIZE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  output var  logic [31:0] HRDATA_OUT,
  output var  logic        HREADYOUT_OUT,
  output var  logic        HRESP_OUT,
  // waveform pin
  output var  logic        PIN_LEVEL_OUT,
  output var  logic        PIN_OE_OUT
);

  // bus address phase
  logic                  ahb_go;
  logic                  wr_pend_r;
  logic [REG_AW-1:0]     wr_addr_r;
  logic [31:0]           rdata_nxt;
  logic                  wr_ctrl;
  logic                  wr_count;
  logic                  wr_compare;
  logic                  wr_status;

  // registers and state
  tpw_ctrl_t             ctrl_r;
  tpw_mode_t             mode;
  logic [7:0]            cnt_r;
  logic [7:0]            cnt_nxt;
  logic                  dir_up_r;
  logic                  dir_up_nxt;
  logic [7:0]            ocr_buf_r;
  logic [7:0]            ocr_act_r;
  logic                  blk_r;
  logic                  ovf_r;
  logic                  mf_r;
  logic                  oc_r;
  logic                  oc_nxt;

  // tick events
  logic                  tick;
  logic                  at_max;
  logic                  at_bottom;
  logic                  match;
  logic                  ovf_set;
  logic                  load_ocr;
  logic                  up_side;

  // decoded from the live control word, so a mode change acts from the
  // very next tick and the count carries over
  assign mode      = tpw_mode_t'(ctrl_r.waveform_mode_sel);
  assign at_max    = cnt_r == CNT_MAX;
  assign at_bottom = cnt_r == CNT_BOTTOM;

  // timer tick as a clock enable, not a clock
  // the tick is registered, so the first one after a clock select write
  // comes one cycle later; no gated clock ever reaches the counter
  tpw_prescaler u_prescaler (
    .clk_in     (CLK_IN),
    .reset_n_in (RESET_N_IN),
    .clk_sel_in (ctrl_r.clk_sel),
    .tick_out   (tick)
  );

  // the slave never stalls: every transfer is one address and one data
  // cycle, answered okay
  assign ahb_go = HSEL_IN & (HTRANS_IN == HTRANS_NONSEQ) & HREADY_IN;

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
    end else begin
      wr_pend_r <= ahb_go & HWRITE_IN;
      wr_addr_r <= HADDR_IN[REG_AW-1:0];
    end
  end

  assign wr_ctrl    = wr_pend_r & (wr_addr_r == OFS_CTRL);
  assign wr_count   = wr_pend_r & (wr_addr_r == OFS_COUNT);
  assign wr_compare = wr_pend_r & (wr_addr_r == OFS_COMPARE);
  assign wr_status  = wr_pend_r & (wr_addr_r == OFS_STATUS);

  // read data is sampled in the address phase; unmapped reads give zero
  // the waveform state bit shows the level even while the pin is an input
  always_comb begin
    rdata_nxt = '0;
    if (ahb_go && !HWRITE_IN) begin
      unique case (HADDR_IN[REG_AW-1:0])
        OFS_CTRL:    rdata_nxt[CTRL_W-1:0] = ctrl_r;
        OFS_COUNT:   rdata_nxt[7:0] = cnt_r;
        OFS_COMPARE: rdata_nxt[7:0] = ocr_buf_r;
        OFS_STATUS: begin
          rdata_nxt[ST_OVF]   = ovf_r;
          rdata_nxt[ST_MATCH] = mf_r;
          rdata_nxt[ST_OCOUT] = oc_r;
        end
        default:     rdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      HRDATA_OUT    <= '0;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT     <= HRESP_OKAY;
    end else begin
      HRDATA_OUT    <= rdata_nxt;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT     <= HRESP_OKAY;
    end
  end

  // control word; its counting fields take hold on the next tick since counting only
  // moves on ticks
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ctrl_r <= tpw_ctrl_t'(CTRL_RESET);
    end else if (wr_ctrl) begin
      ctrl_r <= tpw_ctrl_t'(HWDATA_IN[CTRL_W-1:0]);
    end
  end

  // compare value buffer, written by software at any time
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ocr_buf_r <= CNT_BOTTOM;
    end else if (wr_compare) begin
      ocr_buf_r <= HWDATA_IN[7:0];
    end
  end

  // pwm modes load the active value once per period so a mid-period
  // write cannot cut a pulse short; other modes follow at once
  assign load_ocr = tick & at_max;

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ocr_act_r <= CNT_BOTTOM;
    end else if (mode == MODE_FAST || mode == MODE_PHASE) begin
      if (load_ocr) begin
        ocr_act_r <= ocr_buf_r;
      end
    end else begin
      ocr_act_r <= ocr_buf_r;
    end
  end

  // counting sequence per mode
  // dual slope keeps its direction in a flop of its own: the count alone
  // cannot tell the up slope from the down slope
  always_comb begin
    cnt_nxt    = cnt_r;
    dir_up_nxt = 1'b1;
    unique case (mode)
      MODE_FAST: begin
        cnt_nxt = at_max ? CNT_BOTTOM : cnt_r + 8'h01;
      end
      MODE_PHASE: begin
        dir_up_nxt = dir_up_r;
        if (dir_up_r) begin
          if (at_max) begin
            cnt_nxt    = cnt_r - 8'h01;
            dir_up_nxt = 1'b0;
          end else begin
            cnt_nxt = cnt_r + 8'h01;
          end
        end else begin
          if (at_bottom) begin
            cnt_nxt    = cnt_r + 8'h01;
            dir_up_nxt = 1'b1;
          end else begin
            cnt_nxt = cnt_r - 8'h01;
          end
        end
      end
      MODE_CTC: begin
        cnt_nxt = (cnt_r == ocr_act_r) ? CNT_BOTTOM : cnt_r + 8'h01;
      end
      MODE_NORMAL: begin
        cnt_nxt = cnt_r + 8'h01;
      end
    endcase
  end

  // a software write to the count wins over the tick and keeps the
  // direction, so switching modes never resets the count
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      cnt_r    <= CNT_BOTTOM;
      dir_up_r <= 1'b1;
    end else if (wr_count) begin
      cnt_r <= HWDATA_IN[7:0];
    end else if (tick) begin
      cnt_r    <= cnt_nxt;
      dir_up_r <= dir_up_nxt;
    end
  end

  // a count write masks the compare match of the following tick
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      blk_r <= 1'b0;
    end else if (wr_count) begin
      blk_r <= 1'b1;
    end else if (tick) begin
      blk_r <= 1'b0;
    end
  end

  // compared against the active copy, never the buffer, so in the pwm
  // modes a new value only counts from the period boundary
  assign match = tick & ~blk_r & (cnt_r == ocr_act_r);

  // overflow: max in single-slope modes, bottom in dual-slope mode
  assign ovf_set = tick & ((mode == MODE_PHASE) ? at_bottom
                                                : at_max);

  // flags: write one to clear, a set in the same cycle wins
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      ovf_r <= 1'b0;
      mf_r  <= 1'b0;
    end else begin
      ovf_r <= (ovf_r & ~(wr_status & HWDATA_IN[ST_OVF])) | ovf_set;
      mf_r  <= (mf_r & ~(wr_status & HWDATA_IN[ST_MATCH])) | match;
    end
  end

  // bottom itself counts as the up side, so compare zero holds the up-match level (low in mode 2, high in mode 3)
  assign up_side = dir_up_r | at_bottom;

  // waveform state
  always_comb begin
    oc_nxt = oc_r;
    if (tick) begin
      unique case (mode)
        MODE_FAST: begin
          if (ctrl_r.compare_output_mode[1]) begin
            // bottom action first, so a match at max is dropped
            if (at_max) begin
              oc_nxt = ~ctrl_r.compare_output_mode[0];
            end else if (match) begin
              oc_nxt = ctrl_r.compare_output_mode[0];
            end
          end else if (ctrl_r.compare_output_mode == COM_TOGGLE) begin
            if (match) begin
              oc_nxt = ~oc_r;
            end
          end
        end
        MODE_PHASE: begin
          if (ctrl_r.compare_output_mode[1]) begin
            if (at_max) begin
              // the value entering the comparator decides the top level
              if (ocr_buf_r == CNT_MAX) begin
                oc_nxt = ~ctrl_r.compare_output_mode[0];
              end else begin
                oc_nxt = ctrl_r.compare_output_mode[0];
              end
            end else if (match) begin
              oc_nxt = up_side ? ctrl_r.compare_output_mode[0]
                               : ~ctrl_r.compare_output_mode[0];
            end
          end
        end
        MODE_NORMAL, MODE_CTC: begin
          if (match) begin
            unique case (ctrl_r.compare_output_mode)
              COM_TOGGLE: oc_nxt = ~oc_r;
              COM_CLEAR:  oc_nxt = 1'b0;
              COM_SET:    oc_nxt = 1'b1;
              COM_OFF:    oc_nxt = oc_r;
            endcase
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      oc_r <= 1'b0;
    end else begin
      oc_r <= oc_nxt;
    end
  end

  // the direction bit alone gates the driver, so the level can be
  // prepared while the pin is still an input
  // pin: waveform overrides the port level unless output mode is off;
  // fed from oc_nxt so the pin is not a cycle behind the status bit
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      PIN_LEVEL_OUT <= 1'b0;
      PIN_OE_OUT    <= 1'b0;
    end else begin
      PIN_LEVEL_OUT <= (ctrl_r.compare_output_mode != COM_OFF) ? oc_nxt
                                                 : ctrl_r.port_level;
      PIN_OE_OUT    <= ctrl_r.pin_dir;
    end
  end

endmodule // tpw_timer8_pwm
`default_nettype wire

/* tb/tpw_load.sv */
// load on the waveform pin: resolves the pin and measures its pulses
`timescale 1ns/1ns
`default_nettype none
module tpw_load (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        reset_n_in,
  // pin drive from the timer
  input  wire logic        level_in,
  input  wire logic        oe_in,
  // measurements
  output var  logic        pin_out,
  output var  logic [15:0] period_out,
  output var  logic [15:0] hi_out,
  output var  logic [15:0] rises_out
);
  logic        pin_q_r;
  logic [15:0] gap_r;
  logic [15:0] hi_r;
  // weak pull-down: an undriven pin reads low, never the last level
  assign pin_out = oe_in ? level_in : 1'b0;
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pin_q_r    <= 1'b0;
      gap_r      <= 16'h0;
      hi_r       <= 16'h0;
      period_out <= 16'h0;
      hi_out     <= 16'h0;
      rises_out  <= 16'h0;
    end else begin
      pin_q_r <= pin_out;
      hi_r    <= pin_out ? hi_r + 16'h1 : 16'h0;
      gap_r   <= (pin_out && !pin_q_r) ? 16'h1 : gap_r + 16'h1;
      if (pin_out && !pin_q_r) begin
        period_out <= gap_r;
        rises_out  <= rises_out + 16'h1;
      end
      if (!pin_out && pin_q_r) begin
        hi_out <= hi_r;
      end
    end
  end
endmodule // tpw_load
`default_nettype wire

/* tb/tpw_timer8_pwm_properties.sv */
// concurrent checks on the pwm timer ports
`timescale 1ns/1ns
`default_nettype none
module tpw_timer8_pwm_chk
  import tpw_pkg::*;
(
  // clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        RESET_N_IN,
  // bus
  input  wire logic        HSEL_IN,
  input  wire logic [31:0] HADDR_IN,
  input  wire logic [1:0]  HTRANS_IN,
  input  wire logic        HWRITE_IN,
  input  wire logic [31:0] HWDATA_IN,
  input  wire logic        HREADY_IN,
  input  wire logic [31:0] HRDATA_OUT,
  input  wire logic        HREADYOUT_OUT,
  input  wire logic        HRESP_OUT,
  // pin
  input  wire logic        PIN_LEVEL_OUT,
  input  wire logic        PIN_OE_OUT
);
  // waveform checks wait this long after the last write, past transients
  localparam int SETTLE = 1200;
  logic        ap_go, ap_wr_r, ap_rd_r, lvl_q_r, ok, fast, phs;
  logic [7:0]  ap_a_r, cmp_r;
  logic [1:0]  com;
  logic [11:0] age_r;
  logic [15:0] gap_r, hi_r, cv, e_per, e_hi;
  tpw_ctrl_t   ctl_r;
  assign com   = ctl_r.compare_output_mode;
  assign fast  = ctl_r.waveform_mode_sel == MODE_FAST;
  assign phs   = ctl_r.waveform_mode_sel == MODE_PHASE;
  assign ok    = age_r >= SETTLE && ctl_r.clk_sel == CS_DIV1 && com != COM_OFF;
  assign cv    = {8'h0, cmp_r};
  assign ap_go = HSEL_IN && HTRANS_IN == HTRANS_NONSEQ && HREADY_IN;
  assign e_per = fast ? (com == COM_TOGGLE ? 16'h200 : 16'h100) : 16'h1fe;
  assign e_hi  = fast ? (com == COM_TOGGLE ? 16'h100 :
                 com == COM_CLEAR ? cv + 16'h1 : 16'hff - cv) :
                 (com == COM_CLEAR ? cv << 1 : 16'h1fe - (cv << 1));
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      {ap_wr_r, ap_rd_r, ap_a_r, cmp_r, age_r} <= '0;
      ctl_r <= CTRL_RESET;
    end else begin
      ap_wr_r <= ap_go && HWRITE_IN;
      ap_rd_r <= ap_go && !HWRITE_IN;
      ap_a_r  <= HADDR_IN[7:0];
      if (ap_wr_r) begin
        age_r <= 12'h0;
        if (ap_a_r == OFS_CTRL) ctl_r <= HWDATA_IN[CTRL_W-1:0];
        if (ap_a_r == OFS_COMPARE) cmp_r <= HWDATA_IN[7:0];
      end else if (age_r != 12'hfff) age_r <= age_r + 12'h1;
    end
  end
  always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      {lvl_q_r, gap_r, hi_r} <= '0;
    end else begin
      lvl_q_r <= PIN_LEVEL_OUT;
      hi_r    <= PIN_LEVEL_OUT ? hi_r + 16'h1 : 16'h0;
      gap_r   <= (PIN_LEVEL_OUT && !lvl_q_r) ? 16'h1 : gap_r + 16'h1;
    end
  end
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  ready_okay_a: assert property (
    HREADYOUT_OUT && HRESP_OUT == HRESP_OKAY)
    else $error("bus not ready okay");
  rdata_idle_a: assert property (
    !ap_rd_r |-> HRDATA_OUT == 32'h0) else $error("read data outside phase");
  upper_zero_a: assert property (
    ap_rd_r |-> HRDATA_OUT[31:9] == 23'h0) else $error("upper bits not zero");
  pin_dir_a: assert property (
    age_r >= 4 |-> PIN_OE_OUT == ctl_r.pin_dir)
    else $error("pin enable wrong");
  port_level_a: assert property (
    age_r >= 4 && com == COM_OFF |-> PIN_LEVEL_OUT == ctl_r.port_level)
    else $error("port level not on pin");
  fast_top_a: assert property (
    ok && fast && com[1] && cmp_r == CNT_MAX |-> PIN_LEVEL_OUT == !com[0])
    else $error("fast top level wrong");
  phase_ends_a: assert property (
    ok && phs && com[1] && (cmp_r == CNT_BOTTOM || cmp_r == CNT_MAX)
    |-> PIN_LEVEL_OUT == ((cmp_r == CNT_MAX) ^ com[0]))
    else $error("phase end level wrong");
  wave_period_a: assert property (
    ok && (fast || phs) && $rose(PIN_LEVEL_OUT) |-> gap_r == e_per)
    else $error("period wrong");
  wave_duty_a: assert property (
    ok && (fast || phs) && $fell(PIN_LEVEL_OUT) |-> hi_r == e_hi)
    else $error("high time wrong");
endmodule // tpw_timer8_pwm_chk
bind tpw_timer8_pwm tpw_timer8_pwm_chk u_chk (
  .CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN), .HSEL_IN(HSEL_IN),
  .HADDR_IN(HADDR_IN), .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN),
  .HWDATA_IN(HWDATA_IN), .HREADY_IN(HREADY_IN), .HRDATA_OUT(HRDATA_OUT),
  .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT),
  .PIN_LEVEL_OUT(PIN_LEVEL_OUT), .PIN_OE_OUT(PIN_OE_OUT));
`default_nettype wire

/* tb/tpw_timer8_pwm_bench.sv */
// self-checking bench for the 8-bit pwm timer
`timescale 1ns/1ns
`default_nettype none
module tpw_timer8_pwm_bench
  import tpw_pkg::*;
();
  logic        clk, rst_n, hsel, hwrite, hready, hresp, lvl, oe, pin;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] per, hi, rises, r0;
  int          n_mismatch, samples_checked;
  int          cyc = 0;
  tpw_timer8_pwm uut (.CLK_IN(clk), .RESET_N_IN(rst_n), .HSEL_IN(hsel),
    .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite),
    .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hready),
    .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .PIN_LEVEL_OUT(lvl), .PIN_OE_OUT(oe));
  tpw_load u_load (.clk_in(clk), .reset_n_in(rst_n), .level_in(lvl),
    .oe_in(oe), .pin_out(pin), .period_out(per), .hi_out(hi),
    .rises_out(rises));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [31:0] cf(logic p, logic d, logic [2:0] cs,
                                     logic [1:0] com, logic [1:0] md);
    cf = {23'h0, p, d, cs, com, md};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  // ep of zero: hold the setting only, the checker judges the level
  task automatic run(input logic [2:0] cs, input logic [1:0] com,
    input logic [1:0] md, input logic [7:0] cv, input logic [15:0] ep,
    input logic [15:0] eh);
    bus(1'b1, OFS_COMPARE, {24'h0, cv});
    bus(1'b1, OFS_CTRL, cf(1'b0, 1'b1, cs, com, md));
    repeat (ep == 16'h0 ? 1800 : 4 * ep) @(posedge clk);
    if (ep != 16'h0) begin
      chk({16'h0, per}, {16'h0, ep});
      chk({16'h0, hi}, {16'h0, eh});
    end
  endtask
  task automatic ovf(input logic [1:0] md);
    bus(1'b1, OFS_CTRL, cf(1'b0, 1'b1, CS_STOP, COM_CLEAR, md));
    bus(1'b1, OFS_STATUS, 32'h3);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk({31'h0, rd[ST_OVF]}, 32'h0);
    bus(1'b1, OFS_CTRL, cf(1'b0, 1'b1, CS_DIV1, COM_CLEAR, md));
    repeat (600) @(posedge clk);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk({31'h0, rd[ST_OVF]}, 32'h1);
  endtask
  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 100000) begin
      n_mismatch++;
      results;
    end
  end
  initial begin
    {rst_n, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    // reset values, unmapped place included
    for (int i = 0; i < 5; i++) begin
      bus(1'b0, 8'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    bus(1'b1, 8'h10, 32'hffff_ffff);
    bus(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    bus(1'b1, OFS_CTRL, cf(1'b1, 1'b1, CS_STOP, COM_OFF, MODE_FAST));
    repeat (4) @(posedge clk);
    chk({31'h0, pin}, 32'h1);
    bus(1'b1, OFS_CTRL, cf(1'b1, 1'b0, CS_STOP, COM_OFF, MODE_FAST));
    repeat (4) @(posedge clk);
    chk({31'h0, pin}, 32'h0);
    bus(1'b1, OFS_COUNT, 32'h55);
    bus(1'b1, OFS_CTRL, cf(1'b0, 1'b1, CS_STOP, COM_SET, MODE_PHASE));
    bus(1'b0, OFS_COUNT, 32'h0);
    chk(rd, 32'h55);
    run(CS_DIV1, COM_CLEAR, MODE_FAST, 8'h40, 16'h100, 16'h41);
    bus(1'b0, OFS_COMPARE, 32'h0);
    chk(rd, 32'h40);
    run(CS_DIV1, COM_SET, MODE_FAST, 8'h40, 16'h100, 16'hbf);
    run(CS_DIV1, COM_CLEAR, MODE_FAST, 8'h00, 16'h100, 16'h1);
    run(CS_DIV8, COM_CLEAR, MODE_FAST, 8'h40, 16'h800, 16'h208);
    run(CS_DIV1, COM_TOGGLE, MODE_FAST, 8'h40, 16'h200, 16'h100);
    run(CS_DIV1, COM_CLEAR, MODE_FAST, 8'hff, 16'h0, 16'h0);
    // dual slope started above the compare value, waveform held high
    bus(1'b1, OFS_CTRL, cf(1'b0, 1'b1, CS_STOP, COM_OFF, MODE_NORMAL));
    bus(1'b1, OFS_COMPARE, 32'h40);
    bus(1'b1, OFS_COUNT, 32'h80);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk({31'h0, rd[ST_OCOUT]}, 32'h1);
    bus(1'b1, OFS_CTRL, cf(1'b0, 1'b1, CS_DIV1, COM_CLEAR, MODE_PHASE));
    repeat (200) @(posedge clk);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk({31'h0, rd[ST_OCOUT]}, 32'h0);
    run(CS_DIV1, COM_SET, MODE_FAST, 8'hff, 16'h0, 16'h0);
    run(CS_DIV1, COM_CLEAR, MODE_PHASE, 8'h00, 16'h0, 16'h0);
    run(CS_DIV1, COM_SET, MODE_PHASE, 8'hff, 16'h0, 16'h0);
    run(CS_DIV1, COM_CLEAR, MODE_PHASE, 8'hff, 16'h0, 16'h0);
    run(CS_DIV1, COM_CLEAR, MODE_PHASE, 8'h40, 16'h1fe, 16'h80);
    run(CS_DIV1, COM_SET, MODE_PHASE, 8'h40, 16'h1fe, 16'h17e);
    ovf(MODE_FAST);
    ovf(MODE_PHASE);
    bus(1'b1, OFS_CTRL, cf(1'b0, 1'b0, CS_DIV1, COM_CLEAR, MODE_FAST));
    // the enable flop lags the control write by one edge
    repeat (2) @(posedge clk);
    r0 = rises;
    repeat (600) @(posedge clk);
    chk({16'h0, rises}, {16'h0, r0});
    results;
  end
endmodule // tpw_timer8_pwm_bench
`default_nettype wire
